// >>> design/flash_pin_front.sv
`timescale 1ns/1ps
`default_nettype none
module flash_pin_front #(
  parameter int RX_BUF_DEPTH = flash_pins_pkg::RX_DEPTH,
  parameter int TX_BUF_DEPTH = flash_pins_pkg::TX_DEPTH
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  // Pins from the host
  input  wire logic                        chip_select_n,
  input  wire logic                        serial_clock_in,
  input  wire logic                        serial_in_io0,
  input  wire logic                        write_protect_io2,
  input  wire logic                        pause_line,
  // Pin drive, serial_out_line is lane io1
  output flash_pins_pkg::lanes_t           pad_out,
  output flash_pins_pkg::lanes_t           pad_oe,
  // Configuration from the status registers
  input  wire logic                        quad_enable_bit,
  input  wire logic                        status_protect_hi,
  input  wire logic                        status_protect_lo,
  // Command decoder control
  input  wire logic                        data_out_phase,
  input  wire flash_pins_pkg::xfer_mode_t  read_mode,
  input  wire logic                        array_busy,
  // Received bytes towards the command decoder
  output logic [7:0]                       rx_data,
  output logic                             rx_valid,
  input  wire logic                        rx_ready,
  // Read bytes from the array side
  input  wire logic [7:0]                  tx_data,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  // Status
  output logic                             frame_start,
  output logic                             frame_active,
  output logic                             standby,
  output logic                             transfer_paused,
  output logic                             status_write_block,
  output logic                             rx_overrun
);
  import flash_pins_pkg::*;

  pin_in_t     pin_raw;
  pin_in_t     pin_meta;
  pin_in_t     pin_s;
  logic        sck_prev;
  logic        pause_prev;
  logic        sck_rise;
  logic        sck_fall;
  logic        pause_fall;
  logic        pause_rise;
  link_state_t state;
  link_state_t next_state;
  logic        selected;
  logic        active;
  logic        paused;
  logic [7:0]  rx_shift;
  logic [2:0]  rx_cnt;
  logic        rx_take;
  logic [7:0]  rx_byte;
  logic        rx_push;
  logic        rx_in_ready;
  logic [7:0]  tx_shift;
  logic [3:0]  tx_left;
  logic [7:0]  tx_cur;
  logic [3:0]  tx_bits;
  logic        tx_launch;
  logic        tx_load;
  logic [7:0]  tx_head;
  logic        tx_head_valid;
  lanes_t      lane_bits;

  function automatic logic [3:0] lane_count(input xfer_mode_t m);
    case (m)
      XFER_1_1_2: lane_count = LANE_BITS_2;
      XFER_1_1_4: lane_count = LANE_BITS_4;
      default:    lane_count = LANE_BITS_1;
    endcase
  endfunction

  // Two flops on every pin before use; reset to idle levels so a floating
  // write protect starts deasserted
  assign pin_raw = '{cs_n: chip_select_n, sck: serial_clock_in, io0: serial_in_io0,
                     io2: write_protect_io2, io3: pause_line};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= PIN_IDLE;
      pin_s    <= PIN_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
    end
  end

  // Edges found from the synchronised clock; either idle level works
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev   <= 1'b0;
      pause_prev <= 1'b1;
    end else begin
      sck_prev   <= pin_s.sck;
      pause_prev <= pin_s.io3;
    end
  end

  assign sck_rise   = pin_s.sck && !sck_prev;
  assign sck_fall   = !pin_s.sck && sck_prev;
  assign pause_fall = !pin_s.io3 && pause_prev;
  assign pause_rise = pin_s.io3 && !pause_prev;

  // Framing and standby
  always_comb begin
    case (state)
      ST_STANDBY: next_state = pin_s.cs_n ? ST_STANDBY : ST_SELECT;
      ST_SELECT: begin
        if (!pin_s.cs_n) begin
          next_state = ST_SELECT;
        end else if (array_busy) begin
          next_state = ST_FINISH;
        end else begin
          next_state = ST_STANDBY;
        end
      end
      ST_FINISH: begin
        if (!pin_s.cs_n) begin
          next_state = ST_SELECT;
        end else if (array_busy) begin
          next_state = ST_FINISH;
        end else begin
          next_state = ST_STANDBY;
        end
      end
      default: next_state = ST_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_STANDBY;
      frame_start <= 1'b0;
    end else begin
      state       <= next_state;
      frame_start <= (state != ST_SELECT) && (next_state == ST_SELECT);
    end
  end

  assign selected     = (state == ST_SELECT);
  assign frame_active = selected;
  assign standby      = (state == ST_STANDBY);

  // Pause only while selected and without quad; edges count only with clock low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      paused <= 1'b0;
    end else if (!selected || quad_enable_bit) begin
      paused <= 1'b0;
    end else if (pause_fall && !pin_s.sck) begin
      paused <= 1'b1;
    end else if (pause_rise && !pin_s.sck) begin
      paused <= 1'b0;
    end
  end

  assign active          = selected && !paused;
  assign transfer_paused = paused;

  // Write protect pin only counts in its protecting configuration
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_write_block <= 1'b0;
    end else begin
      status_write_block <= !quad_enable_bit && !status_protect_hi && status_protect_lo
                            && !pin_s.io2;
    end
  end

  // Serial input: one lane for command, address and write data
  assign rx_take = active && sck_rise && !data_out_phase;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift <= '0;
      rx_cnt   <= '0;
    end else if (!selected) begin
      rx_cnt <= '0;
    end else if (rx_take) begin
      rx_shift <= {rx_shift[6:0], pin_s.io0};
      rx_cnt   <= rx_cnt + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_byte <= '0;
      rx_push <= 1'b0;
    end else begin
      rx_push <= rx_take && (rx_cnt == 3'h7);
      if (rx_take && (rx_cnt == 3'h7)) begin
        rx_byte <= {rx_shift[6:0], pin_s.io0};
      end
    end
  end

  // The host cannot be stalled, so a full buffer loses the byte and says so
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_overrun <= 1'b0;
    end else if (rx_push && !rx_in_ready) begin
      rx_overrun <= 1'b1;
    end else if (frame_start) begin
      rx_overrun <= 1'b0;
    end
  end

  stream_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (RX_BUF_DEPTH)
  ) u_rx_buffer (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_data   (rx_byte),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  stream_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (TX_BUF_DEPTH)
  ) u_tx_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (tx_head),
    .out_valid (tx_head_valid),
    .out_ready (tx_load)
  );

  // Serial output: launch on falling edges, lanes set by the read mode
  assign tx_launch = active && data_out_phase && sck_fall;
  assign tx_bits   = lane_count(read_mode);

  always_comb begin
    tx_load = 1'b0;
    tx_cur  = tx_shift;
    if (tx_launch && (tx_left == 4'h0)) begin
      tx_load = tx_head_valid;
      // Starved read shows all ones rather than stale bits
      tx_cur  = tx_head_valid ? tx_head : IDLE_FILL;
    end
  end

  always_comb begin
    lane_bits = '0;
    case (read_mode)
      XFER_1_1_2: begin
        lane_bits.io1 = tx_cur[7];
        lane_bits.io0 = tx_cur[6];
      end
      XFER_1_1_4: begin
        lane_bits.io3 = tx_cur[7];
        lane_bits.io2 = tx_cur[6];
        lane_bits.io1 = tx_cur[5];
        lane_bits.io0 = tx_cur[4];
      end
      default: lane_bits.io1 = tx_cur[7];
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift <= '0;
      tx_left  <= '0;
      pad_out  <= '0;
    end else if (!selected) begin
      tx_left <= '0;
    end else if (tx_launch) begin
      pad_out  <= lane_bits;
      tx_shift <= tx_cur << tx_bits;
      tx_left  <= ((tx_left == 4'h0) ? BITS_PER_BYTE : tx_left) - tx_bits;
    end
  end

  // Drivers released whenever deselected, paused or not in a read data phase
  always_comb begin
    pad_oe     = '0;
    pad_oe.io1 = active && data_out_phase;
    pad_oe.io0 = active && data_out_phase && (read_mode != XFER_1_1_1);
    pad_oe.io2 = active && data_out_phase && (read_mode == XFER_1_1_4)
                 && quad_enable_bit;
    pad_oe.io3 = pad_oe.io2;
  end
endmodule // flash_pin_front
`default_nettype wire

// >>> design/flash_pins_pkg.sv
// How it works
// - Pins are acted on only while chip_select_n is held low, except write_protect_io2, which feeds status_write_block at all times.
// - Deselect means standby once array_busy is low, serial_out_line released to high impedance.
// - Deselected: serial_in_io0 is ignored, no command, address or data taken.
// - Standby after deselect waits until a running program or erase finishes.
// - Command, address and write data are sampled on rising serial clock edges.
// - Read data bits are launched on falling serial clock edges.
// - Multi-lane reads turn serial_in_io0 into an output carrying bit 0.
// - Multi-lane reads keep serial_out_line driving bit 1 of each group.
// - quad_enable_bit 0, protect bits 0 and 1, low write_protect_io2 blocks writes.
// - With quad_enable_bit set, write_protect_io2 serves as data lane 2.
// - A floating write_protect_io2 reads as high through the pull-up.
// - A 256-byte buffer holds incoming bytes; lane use follows transfer mode.
// - Without quad, pause_line falling with clock low pauses, rising resumes.
// - Transfer types name pins used for command, address and data phases.
package flash_pins_pkg;

  localparam int BYTE_BITS = 8;
  localparam int RX_DEPTH  = 256;
  localparam int TX_DEPTH  = 4;
  localparam logic [7:0] IDLE_FILL = 8'hff;
  localparam logic [3:0] LANE_BITS_1 = 4'h1;
  localparam logic [3:0] LANE_BITS_2 = 4'h2;
  localparam logic [3:0] LANE_BITS_4 = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Data phase width, command and address always use one lane
  typedef enum logic [1:0] {
    XFER_1_1_1 = 2'h0,
    XFER_1_1_2 = 2'h1,
    XFER_1_1_4 = 2'h2
  } xfer_mode_t;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_SELECT  = 3'b010,
    ST_FINISH  = 3'b100
  } link_state_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic io0;
    logic io2;
    logic io3;
  } pin_in_t;

  typedef struct packed {
    logic io3;
    logic io2;
    logic io1;
    logic io0;
  } lanes_t;

  // Deselected, clock low, pulled-up pins high
  localparam pin_in_t PIN_IDLE = '{cs_n: 1'b1, sck: 1'b0, io0: 1'b0, io2: 1'b1, io3: 1'b1};

endpackage

// >>> design/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = (count != CW'(DEPTH));
  assign push     = in_valid && in_ready;
  // Output register refills whenever it is empty or being taken
  assign pop      = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end else if (pop) begin
      out_data  <= mem[rd_ptr];
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // stream_fifo
`default_nettype wire

// >>> tb/flash_pin_front_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module flash_pin_front_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Pins and configuration
  input wire logic chip_select_n,
  input wire logic serial_clock_in,
  input wire logic write_protect_io2,
  input wire logic quad_enable_bit,
  input wire logic status_protect_hi,
  input wire logic status_protect_lo,
  input wire logic array_busy,
  input wire flash_pins_pkg::xfer_mode_t read_mode,
  // Observed outputs
  input wire flash_pins_pkg::lanes_t pad_out,
  input wire flash_pins_pkg::lanes_t pad_oe,
  input wire logic frame_start,
  input wire logic standby,
  input wire logic transfer_paused,
  input wire logic status_write_block
);
  import flash_pins_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Long enough to cover the pin synchronisers
  sequence desel_s;
    chip_select_n [*4];
  endsequence
  sequence prot_s;
    (!quad_enable_bit && !status_protect_hi && status_protect_lo && !write_protect_io2) [*5];
  endsequence
  oe_release_a: assert property (desel_s |-> pad_oe == 4'h0)
    else $error("drivers kept while deselected");
  start_seen_a: assert property ($fell(chip_select_n) |-> ##[2:6] frame_start)
    else $error("no frame start after select");
  standby_wait_a: assert property ($rose(standby) |-> !$past(array_busy))
    else $error("standby entered while busy");
  pause_quad_a: assert property (quad_enable_bit [*4] |-> !transfer_paused)
    else $error("paused with quad enabled");
  wp_block_a: assert property (prot_s |-> status_write_block)
    else $error("status writes not blocked");
  lane0_dir_a: assert property (pad_oe.io0 |-> pad_oe.io1 && read_mode != XFER_1_1_1)
    else $error("lane 0 driven outside multi lane read");
  lane2_quad_a: assert property (pad_oe.io2 |-> quad_enable_bit && read_mode == XFER_1_1_4)
    else $error("lane 2 driven outside quad read");
  launch_fall_a: assert property ($changed(pad_out) |-> !serial_clock_in)
    else $error("lane data changed with clock high");
endmodule // flash_pin_front_checker
bind flash_pin_front flash_pin_front_checker u_chk (
  .core_clk, .reset_n, .chip_select_n, .serial_clock_in, .write_protect_io2,
  .quad_enable_bit, .status_protect_hi, .status_protect_lo, .array_busy, .read_mode,
  .pad_out, .pad_oe, .frame_start, .standby, .transfer_paused, .status_write_block
);
`default_nettype wire

// >>> tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Pins towards the device
  output logic chip_select_n,
  output logic serial_clock_in,
  output logic host_si,
  output logic host_pause,
  // Resolved lane levels
  input  wire flash_pins_pkg::lanes_t lanes
);
  logic idle_hi;
  initial begin
    chip_select_n = 1'b1;
    serial_clock_in = 1'b0;
    host_si = 1'b0;
    host_pause = 1'b1;
    idle_hi = 1'b0;
  end
  task automatic start(input logic mode3);
    idle_hi = mode3;
    serial_clock_in = mode3;
    #40 chip_select_n = 1'b0;
  endtask
  task automatic stop();
    #40 serial_clock_in = idle_hi;
    #40 chip_select_n = 1'b1;
    host_si = ~host_si;
  endtask
  // Pause edges only while the clock is low
  task automatic hold(input logic v);
    #40 host_pause = v;
  endtask
  task automatic clocks(input int n, input logic [7:0] pat);
    for (int i = 0; i < n; i++) begin
      host_si = pat[i % 8];
      #40 serial_clock_in = ~serial_clock_in;
    end
  endtask
  task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < 8; i += n) begin
      #40 serial_clock_in = 1'b0;
      // A released lane toggles so a stale level cannot pass
      host_si = (n == 1) ? b[7 - i] : ~host_si;
      #40 serial_clock_in = 1'b1;
      case (n)
        1: r = {r[6:0], lanes.io1};
        2: r = {r[5:0], lanes.io1, lanes.io0};
        default: r = {r[3:0], lanes};
      endcase
    end
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> tb/serial_flash_pin_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module serial_flash_pin_interface_test;
  import flash_pins_pkg::*;
  logic       core_clk, reset_n, chip_select_n, serial_clock_in, host_si, host_pause;
  logic       wp_en, quad_enable_bit, status_protect_hi, status_protect_lo;
  logic       data_out_phase, array_busy, rx_ready, tx_valid, acc;
  logic       rx_valid, tx_ready, frame_start, frame_active, standby;
  logic       transfer_paused, status_write_block, rx_overrun;
  logic [7:0] tx_data, rx_data, b, r, e8, g8;
  xfer_mode_t read_mode;
  lanes_t     pad_out, pad_oe;
  wire lanes_t lanes;
  int         failures = 0, cmp_count = 0, cycles = 0, seed = 74;
  logic [7:0] exp_q[$], got[$], tx_q[$];
  // Lane 2 floats high through the pull-up
  assign lanes = {pad_oe.io3 ? pad_out.io3 : host_pause, pad_oe.io2 ? pad_out.io2 : !wp_en,
                  pad_oe.io1 ? pad_out.io1 : 1'bz, pad_oe.io0 ? pad_out.io0 : host_si};
  spi_host_model host (.chip_select_n, .serial_clock_in, .host_si, .host_pause, .lanes);
  flash_pin_front uut (
    .core_clk, .reset_n, .chip_select_n, .serial_clock_in, .serial_in_io0(lanes.io0),
    .write_protect_io2(lanes.io2), .pause_line(lanes.io3), .pad_out, .pad_oe,
    .quad_enable_bit, .status_protect_hi, .status_protect_lo, .data_out_phase, .read_mode,
    .array_busy, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready,
    .frame_start, .frame_active, .standby, .transfer_paused, .status_write_block, .rx_overrun
  );
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) rx_ready <= $random(seed);
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
    cycles++;
    if (cycles == 60000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check_rx();
    repeat (60) @(negedge core_clk);
    `CHK("rx count", exp_q.size(), got.size())
    `CHK("overrun", 1'b0, rx_overrun)
    while (exp_q.size() > 0 && got.size() > 0) begin
      e8 = exp_q.pop_front();
      g8 = got.pop_front();
      `CHK("rx byte", e8, g8)
    end
    exp_q.delete();
    got.delete();
  endtask
  initial begin
    {quad_enable_bit, status_protect_hi, status_protect_lo, data_out_phase} = 4'h0;
    {array_busy, tx_valid, wp_en, reset_n} = 4'h0;
    tx_data = 8'h00;
    read_mode = XFER_1_1_1;
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    `CHK("standby", 1'b1, standby)
    for (int k = 0; k < 2; k++) begin
      host.start(k[0]);
      repeat (2) begin
        b = $random(seed);
        host.xfer(b, 1, r);
        exp_q.push_back(b);
      end
      host.stop();
      check_rx();
    end
    host.clocks(16, $random(seed));
    check_rx();
    host.start(1'b0);
    host.hold(1'b0);
    repeat (8) @(negedge core_clk);
    `CHK("paused", 1'b1, transfer_paused)
    `CHK("selected", 1'b1, frame_active)
    host.clocks(4, $random(seed));
    host.hold(1'b1);
    repeat (8) @(negedge core_clk);
    `CHK("resumed", 1'b0, transfer_paused)
    b = $random(seed);
    host.xfer(b, 1, r);
    exp_q.push_back(b);
    host.stop();
    check_rx();
    for (int m = 0; m < 3; m++) begin
      quad_enable_bit = (m == 2);
      host.start(m[0]);
      b = $random(seed);
      host.xfer(b, 1, r);
      exp_q.push_back(b);
      // The last command bit is taken a few cycles after its clock edge
      repeat (8) @(negedge core_clk);
      data_out_phase = 1'b1;
      read_mode = xfer_mode_t'(m);
      tx_data = $random(seed);
      tx_valid = 1'b1;
      repeat (8) begin
        acc = tx_ready;
        @(negedge core_clk);
        if (acc === 1'b1) begin
          tx_q.push_back(tx_data);
          tx_data = $random(seed);
        end
      end
      tx_valid = 1'b0;
      `CHK("tx full", 1'b0, tx_ready)
      `CHK("oe", {m == 2, m == 2, 1'b1, m != 0}, pad_oe)
      tx_q.push_back(IDLE_FILL);
      while (tx_q.size() > 0) begin
        b = $random(seed);
        host.xfer(b, 1 << m, r);
        e8 = tx_q.pop_front();
        `CHK("read", e8, r)
      end
      array_busy = 1'b1;
      host.stop();
      repeat (10) @(negedge core_clk);
      `CHK("busy standby", 1'b0, standby)
      `CHK("oe off", 4'h0, pad_oe)
      `CHK("deselected", 1'b0, frame_active)
      array_busy = 1'b0;
      data_out_phase = 1'b0;
      repeat (10) @(negedge core_clk);
      `CHK("standby", 1'b1, standby)
      check_rx();
    end
    for (int i = 0; i < 16; i++) begin
      {quad_enable_bit, status_protect_hi, status_protect_lo} = i[3:1];
      wp_en = !i[0];
      repeat (8) @(negedge core_clk);
      `CHK("wp block", !i[3] && !i[2] && i[1] && !i[0], status_write_block)
    end
    finish_test();
  end
endmodule // serial_flash_pin_interface_test
`default_nettype wire
